// File: isp_i2c_port.sv
// I2C target register port of a supply controller, with Avalon-MM side
// Behaviour
// - Address with direction one starts read mode
// - Read bytes shift out MSB first
// - Master acknowledge starts another read byte
// - Master no-acknowledge releases line, leaves read
// - Status read returns the fault flags
// - Power-good low: ignore bus, never acknowledge
// - Power-good low: all four registers zero
// - Power-good high: bus works, writes accepted
// - Pins low give address 0001000
// - Pins form the two low address bits
// - Threshold bit ORed with threshold pin
// - Enable bit gates both channels
// - Two-bit current limit selection
// - Five separate fault status flags
// - Direction zero writes a control register
`timescale 1ns/1ns
module isp_i2c_port
  import isp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic undervoltage_lockout,
  input wire logic bus_id_pin_lo,
  input wire logic bus_id_pin_hi,
  input wire logic tone_threshold_pin,
  input wire isp_faults_t faults,
  output isp_ctl_t ctl,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  localparam int SYNC_W = 11;
  // Bus lines come out of reset at their idle high level, so no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'h3, 9'h000};

  // ----------------------------------------
  // Input synchronisation and line events
  // ----------------------------------------
  logic [SYNC_W-1:0] syn;
  logic scl_s, sda_s, pg_s, thr_pin_s;
  logic [1:0] pins_s;
  logic [4:0] fault_s;
  logic scl_d_r, sda_d_r;
  logic [4:0] fault_d_r;
  logic scl_rise, scl_fall, start_ev, stop_ev, active;
  logic link_allow_r;

  isp_sync #(.W(SYNC_W), .RST_VAL(SYNC_IDLE)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .d({scl_in, sda_in, undervoltage_lockout, bus_id_pin_hi, bus_id_pin_lo, tone_threshold_pin, faults}),
    .q(syn)
  );
  assign {scl_s, sda_s, pg_s, pins_s, thr_pin_s, fault_s} = syn;

  // Delayed copies for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      fault_d_r <= FIELD_RESET;
    end else if (ce) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      fault_d_r <= fault_s;
    end
  end

  // Clock edges, start and stop conditions
  assign scl_rise = ce & scl_s & ~scl_d_r;
  assign scl_fall = ce & ~scl_s & scl_d_r;
  assign start_ev = ce & scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev = ce & scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign active = pg_s & link_allow_r;

  // ----------------------------------------
  // Protocol state machine
  // ----------------------------------------
  isp_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shq;
  logic rw_r, ack_seen_r, addr_hit, rx_state, ack_state, byte_done;
  logic [1:0] rd_sel_r;
  logic [4:0] tone_r, command_r, control_r, stat_v;

  // Readback byte: select code on top, fields below
  function automatic logic [7:0] reg_byte(input logic [1:0] sel, input logic [4:0] st,
                                          input logic [4:0] tn, input logic [4:0] cm,
                                          input logic [4:0] ct);
    logic [7:0] b;
    b = {CODE_STATUS, st};
    unique case (sel)
      2'h0: b = {CODE_STATUS, st};
      2'h1: b = {CODE_TONE, tn};
      2'h2: b = {CODE_COMMAND, cm};
      2'h3: b = {CODE_CONTROL, ct};
    endcase
    return b;
  endfunction

  assign stat_v = pg_s ? fault_s : FIELD_RESET;
  assign addr_hit = (shq[7:1] == {BUS_ID_HI, pins_s});
  assign rx_state = (state_r == ST_ADDR) || (state_r == ST_WR_BYTE);
  assign ack_state = (state_r == ST_ADDR_ACK) || (state_r == ST_WR_ACK) || (state_r == ST_RD_ACK);
  assign byte_done = (cnt_r == BITS_PER_BYTE);

  // State transitions on start, stop and falling clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      if (!active) begin
        state_r <= ST_IDLE;
      end else if (start_ev) begin
        state_r <= ST_ADDR;
      end else if (stop_ev) begin
        state_r <= ST_IDLE;
      end else if (scl_fall) begin
        unique case (state_r)
          ST_IDLE: state_r <= ST_IDLE;
          ST_ADDR: begin
            if (byte_done) begin
              state_r <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
            end
          end
          ST_ADDR_ACK: state_r <= rw_r ? ST_RD_BYTE : ST_WR_BYTE;
          ST_WR_BYTE: begin
            if (byte_done) begin
              state_r <= ST_WR_ACK;
            end
          end
          ST_WR_ACK: state_r <= ST_WR_BYTE;
          ST_RD_BYTE: begin
            if (cnt_r == READ_LAST_BIT) begin
              state_r <= ST_RD_ACK;
            end
          end
          ST_RD_ACK: state_r <= ack_seen_r ? ST_RD_BYTE : ST_IDLE;
        endcase
      end
    end
  end

  // Bit counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (ce) begin
      if (start_ev || (scl_fall && (ack_state || byte_done))) begin
        cnt_r <= 4'h0;
      end else if ((scl_rise && rx_state) || (scl_fall && state_r == ST_RD_BYTE)) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // Direction bit, master acknowledge and read pointer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rw_r <= 1'b0;
      ack_seen_r <= 1'b0;
      rd_sel_r <= RD_FIRST_SEL;
    end else if (ce) begin
      if (scl_fall && state_r == ST_ADDR && byte_done) begin
        rw_r <= shq[0];
      end
      if (scl_rise && state_r == ST_RD_ACK) begin
        ack_seen_r <= ~sda_s;
      end
      if (scl_fall && state_r == ST_ADDR_ACK) begin
        rd_sel_r <= RD_FIRST_SEL + 2'h1;
      end else if (scl_fall && state_r == ST_RD_ACK && ack_seen_r) begin
        rd_sel_r <= rd_sel_r + 2'h1;
      end
    end
  end

  // Shift register: receive on rising clock, send on falling clock
  isp_shift #(.W(8)) u_shift (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(active & scl_fall & (((state_r == ST_ADDR_ACK) & rw_r) | ((state_r == ST_RD_ACK) & ack_seen_r))),
    .load_val((state_r == ST_ADDR_ACK) ? reg_byte(RD_FIRST_SEL, stat_v, tone_r, command_r, control_r)
                                       : reg_byte(rd_sel_r, stat_v, tone_r, command_r, control_r)),
    .shift_en(active & ((scl_rise & rx_state & ~byte_done) |
                        (scl_fall & (state_r == ST_RD_BYTE) & (cnt_r != READ_LAST_BIT)))),
    .bit_in(rx_state ? sda_s : 1'b1),
    .q(shq)
  );

  // Open-drain data line: acknowledge or send a zero bit
  assign sda_out = 1'b0;
  assign sda_oe = active & ((state_r == ST_ADDR_ACK) | (state_r == ST_WR_ACK) |
                            ((state_r == ST_RD_BYTE) & ~shq[7]));

  // ----------------------------------------
  // System registers
  // ----------------------------------------
  logic wr_commit;
  assign wr_commit = active & scl_fall & (state_r == ST_WR_BYTE) & byte_done;

  // Top bits select, low bits stored; status code stores nothing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tone_r <= FIELD_RESET;
      command_r <= FIELD_RESET;
      control_r <= FIELD_RESET;
    end else if (ce) begin
      if (!pg_s) begin
        tone_r <= FIELD_RESET;
        command_r <= FIELD_RESET;
        control_r <= FIELD_RESET;
      end else if (wr_commit) begin
        unique case (shq[7:5])
          CODE_TONE: tone_r <= shq[4:0];
          CODE_COMMAND: command_r <= shq[4:0];
          CODE_CONTROL: control_r <= shq[4:0];
          default: tone_r <= tone_r;
        endcase
      end
    end
  end

  // Registered control outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= '0;
    end else if (ce) begin
      ctl.chan_en <= {2{control_r[OUT_EN_BIT]}};
      ctl.high_voltage_pick <= control_r[HIGH_V_BIT];
      ctl.low_voltage_pick <= control_r[LOW_V_BIT];
      ctl.tone_on <= tone_r[TONE_ON_BIT];
      ctl.modulation_pick <= tone_r[MOD_PICK_BIT];
      ctl.tone_threshold <= tone_r[TONE_THR_BIT] | thr_pin_s;
      ctl.dynamic_limit_pick <= command_r[DYN_LIMIT_BIT];
      ctl.voltage_pin_allow <= command_r[VPIN_ALLOW_BIT];
      ctl.limit_pick <= {command_r[LIMIT_HI_BIT], command_r[LIMIT_LO_BIT]};
    end
  end

  // ----------------------------------------
  // Avalon-MM slave and interrupts
  // ----------------------------------------
  logic ack_r, bus_req;
  logic [IRQ_W-1:0] irq_sts_r, irq_mask_r, irq_ev;
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;

  // One wait cycle per access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !ack_r) begin
      unique case (avs_address)
        OFS_IRQ_STATUS: avs_readdata <= {28'h000_0000, irq_sts_r};
        OFS_IRQ_MASK: avs_readdata <= {28'h000_0000, irq_mask_r};
        OFS_REGS: avs_readdata <= {reg_byte(2'h3, stat_v, tone_r, command_r, control_r),
                                   reg_byte(2'h2, stat_v, tone_r, command_r, control_r),
                                   reg_byte(2'h1, stat_v, tone_r, command_r, control_r),
                                   reg_byte(2'h0, stat_v, tone_r, command_r, control_r)};
        OFS_LINK_CTRL: avs_readdata <= {30'h0000_0000, state_r != ST_IDLE, link_allow_r};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Events: write byte, read end, fault rise, ignored start
  assign irq_ev[IRQ_WRITE] = wr_commit;
  assign irq_ev[IRQ_READ_END] = active & scl_fall & (state_r == ST_RD_ACK) & ~ack_seen_r;
  assign irq_ev[IRQ_FAULT] = ce & |(fault_s & ~fault_d_r);
  assign irq_ev[IRQ_IGNORED] = start_ev & ~active;

  // Mask, link enable, sticky status with set over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_r <= '0;
      irq_mask_r <= '0;
      link_allow_r <= 1'b1;
    end else if (ce) begin
      if (avs_write && ack_r && avs_address == OFS_IRQ_STATUS) begin
        irq_sts_r <= (irq_sts_r & ~avs_writedata[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_sts_r <= irq_sts_r | irq_ev;
      end
      if (avs_write && ack_r && avs_address == OFS_IRQ_MASK) begin
        irq_mask_r <= avs_writedata[IRQ_W-1:0];
      end
      if (avs_write && ack_r && avs_address == OFS_LINK_CTRL) begin
        link_allow_r <= avs_writedata[LINK_ALLOW_BIT];
      end
    end
  end
  assign irq = |(irq_sts_r & irq_mask_r);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pg_low_silent_a: assert property (!pg_s |-> !sda_oe) else $error("line driven without power");
  pg_low_clear_a: assert property ((!pg_s && ce) |=> (tone_r == FIELD_RESET && command_r == FIELD_RESET
    && control_r == FIELD_RESET)) else $error("registers not cleared");
  addr_pins_a: assert property ((state_r == ST_ADDR && scl_fall && byte_done && active) ##1
    (state_r == ST_ADDR_ACK) |-> $past(shq[7:1], 2) == {BUS_ID_HI, pins_s}) else $error("wrong address");
  addr_zero_a: assert property ((state_r == ST_ADDR && scl_fall && byte_done && active && pins_s == 2'b00
    && shq[7:1] == 7'h08) |=> state_r == ST_ADDR_ACK) else $error("base address missed");
  read_start_a: assert property ((state_r == ST_ADDR_ACK && scl_fall && rw_r && active) |=>
    (state_r == ST_RD_BYTE && shq[7:5] == CODE_STATUS)) else $error("read not started");
  status_flags_a: assert property ((state_r == ST_ADDR_ACK && scl_fall && rw_r && active) |=>
    shq[4:0] == $past(stat_v)) else $error("fault flags not returned");
  read_next_a: assert property ((state_r == ST_RD_ACK && scl_fall && ack_seen_r && active && !start_ev)
    |=> state_r == ST_RD_BYTE) else $error("no next byte");
  read_stop_a: assert property ((state_r == ST_RD_ACK && scl_fall && !ack_seen_r && active) |=>
    (state_r == ST_IDLE && !sda_oe)) else $error("read not ended");
  write_tone_a: assert property ((wr_commit && shq[7:5] == CODE_TONE) ##1 pg_s |->
    tone_r == $past(shq[4:0])) else $error("tone write lost");
  chan_gate_a: assert property ((control_r[OUT_EN_BIT] == 1'b0 && ce) |=> ctl.chan_en == 2'b00)
    else $error("channel on while disabled");
endmodule // isp_i2c_port

// File: isp_pkg.sv
// Constants, field layouts and carrier types of the I2C register port
package isp_pkg;
  // ----------------------------------------
  // Bus address and byte framing
  // ----------------------------------------
  localparam logic [4:0] BUS_ID_HI = 5'h02;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] READ_LAST_BIT = 4'h7;
  localparam logic [1:0] RD_FIRST_SEL = 2'h0;
  // ----------------------------------------
  // Register select codes (top three bits of a byte)
  // ----------------------------------------
  localparam logic [2:0] CODE_STATUS = 3'h0;
  localparam logic [2:0] CODE_TONE = 3'h1;
  localparam logic [2:0] CODE_COMMAND = 3'h2;
  localparam logic [2:0] CODE_CONTROL = 3'h3;
  localparam logic [4:0] FIELD_RESET = 5'h00;
  // ----------------------------------------
  // Field positions inside the low five bits
  // ----------------------------------------
  localparam int TONE_ON_BIT = 4;
  localparam int MOD_PICK_BIT = 3;
  localparam int TONE_THR_BIT = 2;
  localparam int DYN_LIMIT_BIT = 4;
  localparam int VPIN_ALLOW_BIT = 3;
  localparam int LIMIT_HI_BIT = 1;
  localparam int LIMIT_LO_BIT = 0;
  localparam int OUT_EN_BIT = 4;
  localparam int HIGH_V_BIT = 1;
  localparam int LOW_V_BIT = 0;
  // ----------------------------------------
  // Avalon register map and interrupt bits
  // ----------------------------------------
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h0;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [3:0] OFS_REGS = 4'h8;
  localparam logic [3:0] OFS_LINK_CTRL = 4'hC;
  localparam int IRQ_W = 4;
  localparam int IRQ_WRITE = 0;
  localparam int IRQ_READ_END = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_IGNORED = 3;
  localparam int LINK_ALLOW_BIT = 0;
  localparam int LINK_BUSY_BIT = 1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK
  } isp_state_t;
  typedef struct packed {
    logic overtemp_flag;
    logic cable_open_flag;
    logic volt_range_flag;
    logic overload_flag;
    logic backflow_flag;
  } isp_faults_t;
  typedef struct packed {
    logic [1:0] chan_en;
    logic high_voltage_pick;
    logic low_voltage_pick;
    logic tone_on;
    logic modulation_pick;
    logic tone_threshold;
    logic dynamic_limit_pick;
    logic voltage_pin_allow;
    logic [1:0] limit_pick;
  } isp_ctl_t;
endpackage

// File: isp_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module isp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // isp_sync

// File: isp_shift.sv
// Byte shift register, loads in parallel or shifts left MSB first
`timescale 1ns/1ns
module isp_shift #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic shift_en,
  input wire logic bit_in,
  output logic [W-1:0] q
);
  // Load wins over shift
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      if (load) begin
        q <= load_val;
      end else if (shift_en) begin
        q <= {q[W-2:0], bit_in};
      end
    end
  end
endmodule // isp_shift

// File: isp_master_model.sv
// I2C bus master model that drives the register port's link
`timescale 1ns/1ns
module isp_master_model (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ----------------------------------------
  // Bit timing: 4 clk low, 4 clk high (400 ns)
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Data changes only while the clock is low
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    step(2);
    scl <= 1'b1;
    step(2);
    r = sda; // Sampled mid high phase
    step(2);
    scl <= 1'b0;
    step(2);
  endtask
  // Data falls while the clock is high
  task automatic start();
    step(4);
    sda_low <= 1'b1;
    step(4);
    scl <= 1'b0;
    step(2);
  endtask
  // Data rises while the clock is high, clock then stands still
  task automatic stop();
    sda_low <= 1'b1;
    step(2);
    scl <= 1'b1;
    step(4);
    sda_low <= 1'b0;
    step(4);
  endtask
  // Byte out MSB first, ninth clock reads the acknowledge
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Byte in MSB first, acknowledge only when more is wanted
  task automatic rbyte(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(!more, r);
  endtask
endmodule // isp_master_model

// File: test_i2c_slave_register_port.sv
// Self-checking testbench of the I2C register port
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t mismatch", $time); end end
module test_i2c_slave_register_port;
  import isp_pkg::*;
  logic clk_sys, rst_n, m_scl, m_low, sda_oe, undervoltage_lockout;
  logic bus_id_pin_lo, bus_id_pin_hi, tone_threshold_pin, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  isp_faults_t faults;
  isp_ctl_t ctl;
  logic ack;
  logic [7:0] v;
  int miscompares, checks;
  // Open-drain data line with pull-up
  wire logic sda = !(m_low | sda_oe);
  isp_i2c_port DUT (.clk_sys, .rst_n, .ce(1'b1), .scl_in(m_scl), .sda_in(sda), .sda_out(), .sda_oe,
    .undervoltage_lockout, .bus_id_pin_lo, .bus_id_pin_hi, .tone_threshold_pin, .faults, .ctl,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  isp_master_model M (.clk_sys, .sda, .scl(m_scl), .sda_low(m_low));
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Avalon access: held until waitrequest is sampled low at a rising edge
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 20) begin
      @(posedge clk_sys);
      ok = (avs_waitrequest === 1'b0);
      n++;
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!ok) begin
      miscompares++;
      stop_test();
    end
  endtask
  // One write transfer of a single data byte
  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] d, output logic ok);
    logic k;
    M.start();
    M.wbyte({a, 1'b0}, ok);
    if (ok) M.wbyte(d, k);
    M.stop();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pins();
    for (int p = 0; p < 4; p++) begin
      {bus_id_pin_hi, bus_id_pin_lo} <= 2'(p);
      step(6);
      i2c_wr(7'h08 | 7'(p ^ 1), 8'h20, ack);
      `CHK(ack, 1'b0)
      i2c_wr(7'h08 | 7'(p), 8'h20 | 8'(p), ack);
      `CHK(ack, 1'b1)
      av(1'b0, OFS_REGS, '0, q);
      `CHK(q[15:8], 8'h20 | 8'(p))
    end
    {bus_id_pin_hi, bus_id_pin_lo} <= 2'h0;
    step(6);
  endtask
  task automatic t_write();
    M.start();
    M.wbyte(8'h10, ack);
    M.wbyte(8'h34, ack);
    M.wbyte(8'h49, ack);
    M.wbyte(8'h63, ack);
    M.wbyte(8'h1F, ack);
    M.stop();
    `CHK(ctl, 11'h1D5)
    i2c_wr(7'h08, 8'h71, ack);
    `CHK(ctl, 11'h6D5)
    av(1'b0, OFS_REGS, '0, q);
    `CHK(q, 32'h71493400)
    i2c_wr(7'h08, 8'h30, ack);
    `CHK(ctl.tone_threshold, 1'b0)
    tone_threshold_pin <= 1'b1;
    step(6);
    `CHK(ctl.tone_threshold, 1'b1)
    tone_threshold_pin <= 1'b0;
  endtask
  task automatic t_read();
    logic [7:0] e [4];
    e = '{8'h16, 8'h30, 8'h49, 8'h71};
    faults <= 5'b10110;
    step(6);
    M.start();
    M.wbyte(8'h11, ack);
    `CHK(ack, 1'b1)
    for (int k = 0; k < 5; k++) begin
      M.rbyte(k < 4, v);
      `CHK(v, e[k % 4])
    end
    step(4);
    `CHK(sda_oe, 1'b0)
    M.stop();
    av(1'b0, OFS_IRQ_STATUS, '0, q);
    `CHK(q[2:0], 3'h7)
  endtask
  task automatic t_irq();
    av(1'b1, OFS_IRQ_MASK, 32'h7, q);
    step(2);
    `CHK(irq, 1'b1)
    av(1'b1, OFS_IRQ_STATUS, 32'hF, q);
    step(2);
    `CHK(irq, 1'b0)
    av(1'b1, OFS_IRQ_MASK, 32'h0, q);
    i2c_wr(7'h08, 8'h71, ack);
    `CHK(irq, 1'b0)
    av(1'b1, OFS_IRQ_MASK, 32'h1, q);
    step(2);
    `CHK(irq, 1'b1)
    av(1'b1, OFS_IRQ_STATUS, 32'hF, q);
  endtask
  task automatic t_power();
    undervoltage_lockout <= 1'b0;
    step(6);
    `CHK(ctl, 11'h000)
    av(1'b0, OFS_REGS, '0, q);
    `CHK(q, 32'h60402000)
    i2c_wr(7'h08, 8'h71, ack);
    `CHK(ack, 1'b0)
    `CHK(ctl, 11'h000)
    undervoltage_lockout <= 1'b1;
    step(6);
    i2c_wr(7'h08, 8'h71, ack);
    `CHK(ack, 1'b1)
    `CHK(ctl.chan_en, 2'h3)
    av(1'b1, OFS_IRQ_STATUS, 32'hF, q);
    av(1'b1, OFS_LINK_CTRL, 32'h0, q);
    i2c_wr(7'h08, 8'h60, ack);
    `CHK(ack, 1'b0)
    `CHK(ctl.chan_en, 2'h3)
    av(1'b0, OFS_IRQ_STATUS, '0, q);
    `CHK(q[3:0], 4'h8)
    av(1'b1, OFS_LINK_CTRL, 32'h1, q);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    undervoltage_lockout = 1'b1;
    {bus_id_pin_hi, bus_id_pin_lo, tone_threshold_pin} = 3'h0;
    faults = '0;
    {avs_read, avs_write} = 2'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    miscompares = 0;
    checks = 0;
    step(8);
    rst_n <= 1'b1;
    step(4);
    `CHK(ctl, 11'h000)
    av(1'b0, OFS_LINK_CTRL, '0, q);
    `CHK(q, 32'h1)
    t_pins();
    t_write();
    t_read();
    t_irq();
    t_power();
    stop_test();
  end
endmodule // test_i2c_slave_register_port
